// [sim/cbt_chk.sv]
// Purpose: port-level checker for the correlator built-in test block
// Assumes: one clock domain, test pins reach outputs two edges after sampling, scan serial input one edge
// Notes: a shadow of the self-test enable is kept from committed bus writes
`timescale 1ns/10ps
module cbt_chk (
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic I_AVS_WRITE,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic [5:0] I_AVS_ADDRESS,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic I_TMS_ONE,
  input wire logic I_TMS_TWO,
  input wire logic I_SCAN_MODE,
  input wire logic O_SCAN_SHIFT,
  input wire logic I_SCAN_SERIAL_IN,
  input wire logic O_SCAN_SERIAL,
  input wire logic O_FE_TEST,
  input wire logic O_TEST_SIGN,
  input wire logic O_TEST_MAG,
  input wire logic I_TICK,
  input wire logic [6:0] O_TDO,
  input wire logic [6:0] O_TCK_OE,
  input wire logic [6:0] O_AUX_SIGN_OE,
  input wire logic [6:0] I_SCAN_LOOP_OUT,
  input wire logic [6:0] O_AUX_SIGN,
  input wire logic [7:0] O_AUX_MAG,
  input wire logic [9:0] I_SAT_SIGN,
  input wire logic [13:0] I_CH1_I_PROMPT
);
  logic [1:0] up_cnt;
  logic en_q;
  wire wr_bit = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS[5:2] == 4'h0;
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B) begin
      up_cnt <= 2'h0;
      en_q <= 1'h0;
    end else begin
      if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
      if (wr_bit) en_q <= I_AVS_WRITEDATA[5];
    end
  end
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);
  a_normal_tdo_low: assert property ((!I_TMS_ONE && !I_TMS_TWO)[*2] |=>
    O_TDO == 7'h00 && O_TCK_OE == 7'h00 && O_AUX_SIGN_OE == 7'h00) else $error("normal mode drive");
  a_scan_tdo: assert property ((I_TMS_ONE && !I_TMS_TWO && $stable(I_SCAN_LOOP_OUT))[*3]
    |-> O_TDO == I_SCAN_LOOP_OUT) else $error("scan data missing on tdo");
  a_obs_drive: assert property (I_TMS_TWO[*2] |=>
    O_TCK_OE == 7'h7F && O_AUX_SIGN_OE == 7'h7F) else $error("observe pins not driven");
  a_scan_shift: assert property (up_cnt == 2'h3 |->
    O_SCAN_SHIFT == $past(I_SCAN_MODE, 2)) else $error("scan shift wrong");
  a_scan_serial: assert property (up_cnt == 2'h3 |->
    O_SCAN_SERIAL == $past(I_SCAN_SERIAL_IN)) else $error("scan serial wrong");
  a_fe_follow: assert property (wr_bit |-> ##2
    O_FE_TEST == $past(I_AVS_WRITEDATA[0], 2)) else $error("front-end test wrong");
  a_stg_quiet: assert property (!en_q[*4] |->
    !O_TEST_SIGN && !O_TEST_MAG) else $error("generator active while off");
  a_obs_upper: assert property
    ((I_TMS_TWO && !I_TMS_ONE && !I_SAT_SIGN[9] && $stable(I_CH1_I_PROMPT))[*3] |->
    {O_AUX_SIGN[0], O_AUX_MAG[0], O_AUX_SIGN[1], O_AUX_MAG[1], O_AUX_SIGN[2], O_AUX_MAG[2],
    O_AUX_SIGN[3]} == {I_CH1_I_PROMPT[13], I_CH1_I_PROMPT[11:6]}) else $error("obs bits wrong");
  a_obs_tick: assert property ((I_TMS_TWO && !I_TMS_ONE && $stable(I_TICK))[*3] |->
    O_TDO[3] == I_TICK) else $error("tick not on tdo4");
endmodule
bind cbt_top cbt_chk u_cbt_chk (.*);

// [sim/cbt_fe_model.sv]
// Purpose: radio front-end and second receiver seen from the test output
// Assumes: test output is a level; answer lags by P_LAG clocks (1 to 4)
// Notes: i_fail makes the second receiver report a failed self-test
`timescale 1ns/10ps
module cbt_fe_model #(
  parameter int unsigned P_LAG = 1
) (
  input wire logic i_clk,
  input wire logic i_test,
  input wire logic i_fail,
  output logic o_lock,
  output logic o_pass
);
  logic [3:0] test_dly;
  always_ff @(posedge i_clk) test_dly <= {test_dly[2:0], i_test};
  // synthesiser unlocks while test is held
  assign o_lock = !test_dly[P_LAG-1];
  assign o_pass = test_dly[P_LAG-1] && !i_fail;
endmodule

// [sim/testbench.sv]
// Purpose: self-checking bench for the correlator built-in test block
// Assumes: Avalon slave answers after one wait cycle, data bit period 200
// Notes: bench signals carry the port names so the instance connects by name
`timescale 1ns/10ps
module testbench;
  import cbt_pkg::*;
  logic I_MCLK, I_RST_B, I_AVS_READ, I_AVS_WRITE, O_AVS_WAITREQUEST, fe_fail;
  logic [5:0] I_AVS_ADDRESS, O_CH_SIGN, O_CH_MAG;
  logic [31:0] I_AVS_WRITEDATA, O_AVS_READDATA, rdata;
  logic [9:0] I_SAT_SIGN, I_SAT_MAG;
  logic [6:0] O_AUX_SIGN, O_AUX_SIGN_OE, O_TDO, I_SCAN_LOOP_OUT, I_INT_PHASE, I_TCK;
  logic [6:0] O_TCK, O_TCK_OE, O_CLK_PHASE;
  logic [7:0] O_AUX_MAG, O_AUX_MAG_OE;
  logic [27:0] I_CH1_CARR_PHASE, I_CH2_CARR_PHASE;
  logic [13:0] I_CH1_I_PROMPT, I_CH1_I_DITH, I_CH1_Q_PROMPT, I_CH1_Q_DITH;
  logic [15:0] I_CH1_MIX;
  logic [2:0] I_MARK_FB;
  logic I_CH1_PROMPT_CODE, I_CH2_PROMPT_CODE, O_TEST_SIGN, O_TEST_MAG, O_FE_TEST, I_FE_LOCK;
  logic I_SECOND_RX_PASS, I_SECOND_MARK, I_CHANNEL_ONE_DUMP_SIGNAL, O_TIME_MARK, I_SCAN_MODE, I_SCAN_SERIAL_IN;
  logic O_SCAN_SHIFT, O_SCAN_SERIAL, I_TEST_CLK_SEL, I_TMS_ONE, I_TMS_TWO, I_CH1_CODE_CLK;
  logic I_CH1_DITH_CODE, I_CH1_PRESET_LOAD, I_TICK, I_CH1_EPOCH_CARRY, I_STATUS_LATCH;
  logic I_CH1_SAMPLED_SIGN, I_CH1_SAMPLED_MAG, I_CODE_GEN_RESET;
  int failures = 0;
  int n_tests = 0;
  int hi;
  // {top five phase bits, magnitude}
  logic [5:0] wc_rows [10] = '{6'h14, 6'h17, 6'h19, 6'h1F, 6'h21, 6'h27, 6'h29, 6'h2A, 6'h3E, 6'h00};
  // {select two, select one, sign nine, enables, test data outputs}
  logic [10:0] md_rows [5] = '{11'h000, 11'h255, 11'h4B7, 11'h6B5, 11'h5B7};
  cbt_top #(.P_BIT_CYCLES(200)) u_cbt_top (.*);
  cbt_fe_model #(.P_LAG(3)) u_cbt_fe_model (.i_clk(I_MCLK), .i_test(O_FE_TEST),
    .i_fail(fe_fail), .o_lock(I_FE_LOCK), .o_pass(I_SECOND_RX_PASS));
  initial I_MCLK = 1'b0;
  always #50 I_MCLK = ~I_MCLK;
  task automatic summarize();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge I_MCLK);
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    I_AVS_ADDRESS <= a;
    I_AVS_WRITEDATA <= d;
    I_AVS_WRITE <= wr;
    I_AVS_READ <= !wr;
    @(posedge I_MCLK);
    // only the watchdog ends a wait that never sees waitrequest low
    while (O_AVS_WAITREQUEST !== 1'b0) begin
      @(posedge I_MCLK);
    end
    rdata = O_AVS_READDATA;
    I_AVS_WRITE <= 1'b0;
    I_AVS_READ <= 1'b0;
    @(posedge I_MCLK);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    check(nm, rdata & m, e);
  endtask
  initial begin
    #1_000_000;
    failures++;
    summarize();
  end
  initial begin
    {I_RST_B, I_AVS_READ, I_AVS_WRITE, I_SAT_SIGN, I_SAT_MAG, I_CH1_CARR_PHASE, I_CH2_CARR_PHASE,
      I_CH1_PROMPT_CODE, I_CH2_PROMPT_CODE, I_MARK_FB, I_SECOND_MARK, I_CHANNEL_ONE_DUMP_SIGNAL, I_SCAN_MODE,
      I_SCAN_SERIAL_IN, I_TEST_CLK_SEL, I_TMS_ONE, I_TMS_TWO, I_CODE_GEN_RESET, I_TICK,
      I_CH1_SAMPLED_SIGN, I_CH1_SAMPLED_MAG, I_STATUS_LATCH, fe_fail} <= '0;
    {I_CH1_CODE_CLK, I_CH1_DITH_CODE, I_CH1_PRESET_LOAD, I_CH1_EPOCH_CARRY} <= 4'hB;
    I_AVS_ADDRESS <= 6'h00;
    I_AVS_WRITEDATA <= 32'h0;
    {I_SCAN_LOOP_OUT, I_INT_PHASE, I_TCK} <= {7'h55, 7'h64, 7'h1B};
    {I_CH1_I_PROMPT, I_CH1_I_DITH, I_CH1_Q_PROMPT, I_CH1_Q_DITH} <= {14'h2A55, 14'h1000, 14'h0, 14'h1000};
    I_CH1_MIX <= 16'h9ABC;
    tick(2);
    check("reset bus", 32'({O_AVS_WAITREQUEST, O_FE_TEST, O_TDO}), 32'h100);
    I_RST_B <= 1'b1;
    tick(2);
    rd(OFS_BIT, 32'hFFFF, 32'h0, "test reg reset");
    rd(6'h10, 32'hFFFFFFFF, 32'h0, "unmapped");
    I_CH1_CARR_PHASE <= {5'h10, 23'h0};
    {I_SAT_SIGN, I_SAT_MAG} <= {10'h209, 10'h008};
    bus(1'b1, OFS_SRCSEL, 32'hAF390A);
    bus(1'b1, OFS_BIT, 32'h0020);
    tick(4);
    check("ch sign", 32'(O_CH_SIGN), 32'h2F);
    check("ch mag", 32'(O_CH_MAG), 32'h29);
    for (int i = 0; i < 10; i++) begin
      I_CH1_CARR_PHASE <= {wc_rows[i][5:1], 23'h0};
      tick(4);
      check("stg mag", 32'(O_TEST_MAG), 32'(wc_rows[i][0]));
      check("stg sign", 32'(O_TEST_SIGN), 32'(wc_rows[i][5]));
    end
    {I_CH1_CARR_PHASE, I_CH2_CARR_PHASE, I_CH2_PROMPT_CODE} <= {28'h0, 5'h0C, 23'h0, 1'b1};
    bus(1'b1, OFS_BIT, 32'h0060);
    tick(4);
    check("ch2 source", 32'({O_TEST_SIGN, O_TEST_MAG}), 32'h3);
    I_CH1_CARR_PHASE <= {5'h10, 23'h0};
    bus(1'b1, OFS_BIT, 32'h0000);
    tick(4);
    check("stg off", 32'({O_TEST_SIGN, O_TEST_MAG}), 32'h0);
    bus(1'b1, OFS_BIT, 32'h0020);
    tick(150);
    check("data bit low", 32'({O_TEST_SIGN, O_TEST_MAG}), 32'h3);
    tick(100);
    check("data bit high", 32'({O_TEST_SIGN, O_TEST_MAG}), 32'h1);
    tick(200);
    check("data bit low again", 32'({O_TEST_SIGN, O_TEST_MAG}), 32'h3);
    rd(OFS_STATUS, 32'h3, 32'h1, "locked");
    bus(1'b1, OFS_BIT, 32'h0001);
    tick(8);
    check("fe test", 32'(O_FE_TEST), 32'h1);
    rd(OFS_STATUS, 32'h3, 32'h2, "unlocked pass");
    fe_fail <= 1'b1;
    tick(8);
    rd(OFS_STATUS, 32'h3, 32'h0, "second fail");
    bus(1'b1, OFS_BIT, 32'h0000);
    I_SECOND_MARK <= 1'b1;
    tick(4);
    check("normal mark", 32'(O_TIME_MARK), 32'h1);
    {I_SECOND_MARK, I_CHANNEL_ONE_DUMP_SIGNAL} <= 2'b01;
    bus(1'b1, OFS_TIMER, 32'h0110);
    tick(4);
    check("dump mark", 32'(O_TIME_MARK), 32'h1);
    bus(1'b1, OFS_TIMER, 32'h0010);
    hi = 0;
    for (int i = 0; i < 182; i++) begin
      @(posedge I_MCLK);
      hi += (O_TIME_MARK === 1'b1);
    end
    check("div91 highs", 32'(hi), 32'd92);
    bus(1'b1, OFS_TIMER, 32'h00A0);
    I_MARK_FB <= 3'b001;
    tick(4);
    rd(OFS_STATUS, 32'h78, 32'h48, "mark fb0");
    I_MARK_FB <= 3'b010;
    tick(4);
    rd(OFS_STATUS, 32'h78, 32'h10, "mark fb1");
    {I_CH1_CARR_PHASE, I_CH1_PROMPT_CODE} <= {28'hA000000, 1'b1};
    for (int i = 0; i < 5; i++) begin
      {I_TMS_TWO, I_TMS_ONE, I_SAT_SIGN[9]} <= md_rows[i][10:8];
      tick(4);
      check("tdo", 32'(O_TDO), 32'(md_rows[i][6:0]));
      check("oe", 32'({O_TCK_OE, O_AUX_MAG_OE}), 32'({15{md_rows[i][7]}}));
    end
    I_TMS_ONE <= 1'b1;
    tick(4);
    check("obs lower dith", 32'({O_AUX_SIGN[0], O_AUX_MAG[0], O_AUX_MAG[3], O_TCK[5:2]}), 32'h59);
    {I_TMS_TWO, I_TMS_ONE, I_SCAN_MODE, I_SCAN_SERIAL_IN} <= 4'h3;
    for (int s = 0; s < 2; s++) begin
      I_TEST_CLK_SEL <= s[0];
      tick(4);
      check("clk phase", 32'(O_CLK_PHASE), s ? 32'h1B : 32'h64);
    end
    check("scan ctl", 32'({O_SCAN_SHIFT, O_SCAN_SERIAL}), 32'h3);
    // reset in mid-run clears registers and pin drivers, then pins follow again
    I_RST_B <= 1'b0;
    tick(2);
    check("mid reset", 32'({O_AVS_WAITREQUEST, O_SCAN_SHIFT, O_SCAN_SERIAL, O_CLK_PHASE}), 32'h200);
    I_RST_B <= 1'b1;
    tick(2);
    rd(OFS_TIMER, 32'hFFFF, 32'h0, "timer after reset");
    rd(OFS_SRCSEL, 32'hFFFFFF, 32'h0, "srcsel after reset");
    check("scan after reset", 32'({O_SCAN_SHIFT, O_SCAN_SERIAL}), 32'h3);
    check("clk after reset", 32'(O_CLK_PHASE), 32'h1B);
    summarize();
  end
endmodule

// [verilog/cbt_pkg.sv]
// Purpose: shared constants and types for the correlator built-in test block
// Assumes: 10 MHz master clock, Avalon-MM register slave with 32-bit data
// Notes: byte offsets, field positions and reset values live here only
package cbt_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned STG_BIT_MS = 20;
  localparam int unsigned STG_BIT_CYCLES = STG_BIT_MS * (CLK_HZ / 1000);
  localparam int unsigned NCH = 6;
  localparam int unsigned NPH = 7;
  localparam int unsigned PH_W = 28;
  localparam int unsigned ACC_W = 14;
  localparam int unsigned AW = 6;
  localparam int unsigned DW = 32;
  localparam int unsigned SRC_W = 4;
  // byte offsets
  localparam logic [AW-1:0] OFS_BIT = 6'h00;
  localparam logic [AW-1:0] OFS_TIMER = 6'h04;
  localparam logic [AW-1:0] OFS_SRCSEL = 6'h08;
  localparam logic [AW-1:0] OFS_STATUS = 6'h0C;
  // builtin_test_register fields
  localparam int unsigned BIT_FE_TEST = 0;
  localparam int unsigned BIT_STG_EN = 5;
  localparam int unsigned BIT_STG_SRC = 6;
  localparam logic [15:0] BIT_RST = 16'h0000;
  // timer_control_register fields
  localparam int unsigned TMR_TEST_EN = 4;
  localparam int unsigned TMR_FB_LO = 5;
  localparam int unsigned TMR_FB_HI = 7;
  localparam int unsigned TMR_TEST_SEL = 8;
  localparam logic [15:0] TMR_RST = 16'h0000;
  localparam logic [NCH*SRC_W-1:0] SRCSEL_RST = 24'h000000;
  localparam logic [SRC_W-1:0] SRC_SELFTEST = 4'hA;
  // master clock divided by 91
  localparam logic [6:0] DIV91_LAST = 7'h5A;
  localparam logic [6:0] DIV91_HALF = 7'h2E;
  // weight converter codes on the top five carrier phase bits
  localparam logic [4:0] WC_CODE_A = 5'h0B;
  localparam logic [2:0] WC_PFX_B = 3'h3;
  localparam logic [2:0] WC_PFX_C = 3'h4;
  localparam logic [4:0] WC_CODE_D = 5'h14;
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_SCAN = 3'b010,
    MODE_OBS = 3'b100
  } cbt_mode_t;
endpackage

// [verilog/cbt_stg.sv]
// Purpose: self-test pattern generator with carrier weight converter
// Assumes: source channel phase and code arrive already selected
// Notes: data bit period is a parameter so simulation can shorten it
`timescale 1ns/10ps
module cbt_stg #(
  parameter int unsigned P_BIT_CYCLES = cbt_pkg::STG_BIT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  cbt_stg_if.gen stg
);
  import cbt_pkg::*;

  logic [17:0] cnt_reg;
  logic [17:0] cnt_next;
  logic bit_reg;
  logic bit_next;
  logic wc_mag;
  logic wc_sign;
  logic cnt_wrap;

  assign wc_mag = (stg.phase_top == WC_CODE_A) || (stg.phase_top[4:2] == WC_PFX_B)
                  || (stg.phase_top[4:2] == WC_PFX_C) || (stg.phase_top == WC_CODE_D);
  assign wc_sign = stg.phase_top[4];
  assign cnt_wrap = (cnt_reg == 18'(P_BIT_CYCLES - 1));
  assign cnt_next = (!stg.enable || cnt_wrap) ? 18'h00000 : cnt_reg + 18'h00001;
  // first bit after enable is low, then toggles each period
  assign bit_next = !stg.enable ? 1'b0 : (cnt_wrap ? !bit_reg : bit_reg);

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_reg <= 18'h00000;
      bit_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
    end
  end

  // code and data modulate the converter sign; idle generator outputs zero
  assign stg.sign = stg.enable & (wc_sign ^ stg.code ^ bit_reg);
  assign stg.mag = stg.enable & wc_mag;
  assign stg.data_bit = bit_reg;
endmodule

// [verilog/cbt_stg_if.sv]
// Purpose: link between the test block and its self-test pattern generator
// Assumes: single clock domain
// Notes: ctl side feeds the source channel state, gen side returns samples
`timescale 1ns/10ps
interface cbt_stg_if;
  logic enable;
  logic [4:0] phase_top;
  logic code;
  logic sign;
  logic mag;
  logic data_bit;
  modport ctl (output enable, output phase_top, output code,
               input sign, input mag, input data_bit);
  modport gen (input enable, input phase_top, input code,
               output sign, output mag, output data_bit);
endinterface

// [verilog/cbt_top.sv]
// Purpose: correlator built-in and manufacturing test logic
// Assumes: test pins synchronous to I_MCLK; channels own their scan loops
// Notes: every output is registered; outputs fed from registered mode, scan and clock select pins lag those pins by two cycles
`timescale 1ns/10ps
// Overview of operation
// - self-test generator runs only while enabled
// - generator uses channel 1 or 2 by select
// - channels selecting self-test take generator samples
// - data bit toggles every 20 ms, low first
// - code and Doppler follow source channel settings
// - self-test sign and magnitude drive test pins
// - weight converter table; sign equals phase MSB
// - writing 0020 enables generator from channel 1
// - front-end test output unlocks front-end synthesiser
// - same output tests second receiver; pass input
// - three mark feedbacks selected by timer bits 7:5
// - timer bits 4,8 choose mark source
// - each channel has one scan loop
// - shared scan input, seven scan outputs
// - scan pin high selects shift mode
// - clock select replaces phases by test clocks
// - both mode selects low: inputs, outputs low
// - mode one high, mode two low: scan data on outputs
// - mode two high: aux pins observe channel 1
// - arm and bit-half selection of observed accumulators
// - test outputs carry channel 1 timing nodes
module cbt_top #(
  parameter int unsigned P_BIT_CYCLES = cbt_pkg::STG_BIT_CYCLES
) (
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic [cbt_pkg::AW-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [cbt_pkg::DW-1:0] I_AVS_WRITEDATA,
  output logic [cbt_pkg::DW-1:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic [9:0] I_SAT_SIGN,
  input wire logic [9:0] I_SAT_MAG,
  output logic [6:0] O_AUX_SIGN,
  output logic [6:0] O_AUX_SIGN_OE,
  output logic [7:0] O_AUX_MAG,
  output logic [7:0] O_AUX_MAG_OE,
  output logic [cbt_pkg::NCH-1:0] O_CH_SIGN,
  output logic [cbt_pkg::NCH-1:0] O_CH_MAG,
  input wire logic [cbt_pkg::PH_W-1:0] I_CH1_CARR_PHASE,
  input wire logic [cbt_pkg::PH_W-1:0] I_CH2_CARR_PHASE,
  input wire logic I_CH1_PROMPT_CODE,
  input wire logic I_CH2_PROMPT_CODE,
  output logic O_TEST_SIGN,
  output logic O_TEST_MAG,
  output logic O_FE_TEST,
  input wire logic I_FE_LOCK,
  input wire logic I_SECOND_RX_PASS,
  input wire logic [2:0] I_MARK_FB,
  input wire logic I_SECOND_MARK,
  input wire logic I_CHANNEL_ONE_DUMP_SIGNAL,
  output logic O_TIME_MARK,
  input wire logic I_SCAN_MODE,
  input wire logic I_SCAN_SERIAL_IN,
  output logic O_SCAN_SHIFT,
  output logic O_SCAN_SERIAL,
  input wire logic [6:0] I_SCAN_LOOP_OUT,
  input wire logic I_TEST_CLK_SEL,
  input wire logic I_TMS_ONE,
  input wire logic I_TMS_TWO,
  input wire logic [cbt_pkg::NPH-1:0] I_INT_PHASE,
  input wire logic [cbt_pkg::NPH-1:0] I_TCK,
  output logic [cbt_pkg::NPH-1:0] O_TCK,
  output logic [cbt_pkg::NPH-1:0] O_TCK_OE,
  output logic [cbt_pkg::NPH-1:0] O_CLK_PHASE,
  output logic [6:0] O_TDO,
  input wire logic [cbt_pkg::ACC_W-1:0] I_CH1_I_PROMPT,
  input wire logic [cbt_pkg::ACC_W-1:0] I_CH1_I_DITH,
  input wire logic [cbt_pkg::ACC_W-1:0] I_CH1_Q_PROMPT,
  input wire logic [cbt_pkg::ACC_W-1:0] I_CH1_Q_DITH,
  input wire logic [15:0] I_CH1_MIX,
  input wire logic I_CH1_CODE_CLK,
  input wire logic I_CH1_DITH_CODE,
  input wire logic I_CH1_PRESET_LOAD,
  input wire logic I_TICK,
  input wire logic I_CH1_EPOCH_CARRY,
  input wire logic I_STATUS_LATCH,
  input wire logic I_CH1_SAMPLED_SIGN,
  input wire logic I_CH1_SAMPLED_MAG,
  input wire logic I_CODE_GEN_RESET
);
  import cbt_pkg::*;

  cbt_stg_if stg_if ();

  // register file
  logic [15:0] bit_reg;
  logic [15:0] bit_next;
  logic [15:0] tmr_reg;
  logic [15:0] tmr_next;
  logic [NCH*SRC_W-1:0] src_reg;
  logic [NCH*SRC_W-1:0] src_next;
  logic wait_reg;
  logic wait_next;
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rdata_next;
  // test pin controls
  cbt_mode_t mode_reg;
  cbt_mode_t mode_next;
  logic test_clock_select_pin_reg;
  logic scan_reg;
  logic test_mode_select_one_reg;
  logic input_sign_nine_reg;
  logic [6:0] div_reg;
  logic [6:0] div_next;
  logic [NCH-1:0] ch_sign_next;
  logic [NCH-1:0] ch_mag_next;
  // observability
  logic [ACC_W-1:0] acc_i;
  logic [ACC_W-1:0] acc_q;
  logic [6:0] obs_i;
  logic [6:0] obs_q;
  logic [3:0] obs_mix;
  logic [6:0] obs_sign;
  logic [7:0] obs_mag;
  logic [6:0] obs_tck;
  logic [6:0] obs_tdo;
  logic [6:0] tdo_next;
  logic obs_on;
  logic [PH_W-1:0] ch1_ph;
  // bus decode
  logic req;
  logic take;
  logic wr_take;
  logic hit_bit;
  logic hit_tmr;
  logic hit_src;
  logic hit_sts;
  logic [2:0] fb_sel;
  logic fb_hit;
  logic div_wave;
  logic mark_next;
  logic [DW-1:0] sts_word;

  assign req = I_AVS_READ | I_AVS_WRITE;
  assign take = req & wait_reg;
  assign wr_take = I_AVS_WRITE & !wait_reg;
  assign hit_bit = (I_AVS_ADDRESS[AW-1:2] == OFS_BIT[AW-1:2]);
  assign hit_tmr = (I_AVS_ADDRESS[AW-1:2] == OFS_TIMER[AW-1:2]);
  assign hit_src = (I_AVS_ADDRESS[AW-1:2] == OFS_SRCSEL[AW-1:2]);
  assign hit_sts = (I_AVS_ADDRESS[AW-1:2] == OFS_STATUS[AW-1:2]);
  // one wait cycle, then a single cycle with waitrequest low
  assign wait_next = !take;
  assign bit_next = (wr_take && hit_bit) ? I_AVS_WRITEDATA[15:0] : bit_reg;
  assign tmr_next = (wr_take && hit_tmr) ? I_AVS_WRITEDATA[15:0] : tmr_reg;
  assign src_next = (wr_take && hit_src) ? I_AVS_WRITEDATA[NCH*SRC_W-1:0] : src_reg;

  // status: lock, second receiver pass, data bit, raw and selected feedback
  assign fb_sel = tmr_reg[TMR_FB_HI:TMR_FB_LO];
  assign fb_hit = |(fb_sel & I_MARK_FB);
  assign sts_word = {25'h0000000, fb_hit, I_MARK_FB, stg_if.data_bit,
                     I_SECOND_RX_PASS, I_FE_LOCK};
  assign rdata_next = !take ? rdata_reg :
                      (I_AVS_WRITE ? 32'h00000000 :
                      (hit_bit ? {16'h0000, bit_reg} :
                      (hit_tmr ? {16'h0000, tmr_reg} :
                      (hit_src ? {8'h00, src_reg} :
                      (hit_sts ? sts_word : 32'h00000000)))));

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B) begin
      bit_reg <= BIT_RST;
      tmr_reg <= TMR_RST;
      src_reg <= SRCSEL_RST;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      bit_reg <= bit_next;
      tmr_reg <= tmr_next;
      src_reg <= src_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign O_AVS_WAITREQUEST = wait_reg;
  assign O_AVS_READDATA = rdata_reg;

  // self-test generator source
  assign stg_if.enable = bit_reg[BIT_STG_EN];
  assign stg_if.phase_top = bit_reg[BIT_STG_SRC] ? I_CH2_CARR_PHASE[PH_W-1 -: 5]
                                                 : I_CH1_CARR_PHASE[PH_W-1 -: 5];
  assign stg_if.code = bit_reg[BIT_STG_SRC] ? I_CH2_PROMPT_CODE : I_CH1_PROMPT_CODE;

  cbt_stg #(
    .P_BIT_CYCLES(P_BIT_CYCLES)
  ) u_stg (
    .i_clk(I_MCLK),
    .i_rst_b(I_RST_B),
    .stg(stg_if.gen)
  );

  // per-channel input source selection
  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc = gc + 1) begin : g_ch
      logic [SRC_W-1:0] sel;
      assign sel = src_reg[gc*SRC_W +: SRC_W];
      assign ch_sign_next[gc] = (sel == SRC_SELFTEST) ? stg_if.sign :
                                ((sel < SRC_SELFTEST) ? I_SAT_SIGN[sel] : 1'b0);
      assign ch_mag_next[gc] = (sel == SRC_SELFTEST) ? stg_if.mag :
                               ((sel < SRC_SELFTEST) ? I_SAT_MAG[sel] : 1'b0);
    end
  endgenerate

  // time mark source and master clock divided by 91
  assign div_next = (div_reg == DIV91_LAST) ? 7'h00 : div_reg + 7'h01;
  assign div_wave = (div_reg < DIV91_HALF);
  assign mark_next = !tmr_reg[TMR_TEST_EN] ? I_SECOND_MARK :
                     (tmr_reg[TMR_TEST_SEL] ? I_CHANNEL_ONE_DUMP_SIGNAL : div_wave);

  // test mode decode from raw pins, registered into mode_reg
  assign mode_next = I_TMS_TWO ? MODE_OBS :
                     (I_TMS_ONE ? MODE_SCAN : MODE_NORMAL);
  assign obs_on = (mode_reg == MODE_OBS);

  // observed accumulators: prompt or dithering arm, upper or lower half
  assign acc_i = test_mode_select_one_reg ? I_CH1_I_DITH : I_CH1_I_PROMPT;
  assign acc_q = test_mode_select_one_reg ? I_CH1_Q_DITH : I_CH1_Q_PROMPT;
  assign obs_i = input_sign_nine_reg ? {acc_i[12], acc_i[5:0]} : {acc_i[13], acc_i[11:6]};
  assign obs_q = input_sign_nine_reg ? {acc_q[12], acc_q[5:0]} : {acc_q[13], acc_q[11:6]};
  assign obs_mix = I_CH1_MIX[{input_sign_nine_reg, test_mode_select_one_reg, 2'b00} +: 4];
  assign obs_sign = {obs_q[1], obs_q[3], obs_q[5], obs_i[0], obs_i[2], obs_i[4], obs_i[6]};
  assign obs_mag = {1'b0, obs_q[0], obs_q[2], obs_q[4], obs_q[6], obs_i[1], obs_i[3],
                    obs_i[5]};
  assign obs_tck = {I_CODE_GEN_RESET, obs_mix, I_CH1_SAMPLED_MAG, I_CH1_SAMPLED_SIGN};
  assign ch1_ph = I_CH1_CARR_PHASE;
  assign obs_tdo = test_mode_select_one_reg ?
    {I_STATUS_LATCH, I_CH1_EPOCH_CARRY, ch1_ph[27], ch1_ph[26], ch1_ph[25],
     I_CH1_DITH_CODE, I_CH1_CODE_CLK} :
    {I_STATUS_LATCH, I_CH1_EPOCH_CARRY, ch1_ph[27], I_TICK, I_CH1_PRESET_LOAD,
     I_CH1_PROMPT_CODE, I_CH1_CODE_CLK};

  always_comb begin
    unique case (mode_reg)
      MODE_NORMAL: tdo_next = 7'h00;
      MODE_SCAN: tdo_next = I_SCAN_LOOP_OUT;
      MODE_OBS: tdo_next = obs_tdo;
      default: tdo_next = 7'h00;
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B) begin
      mode_reg <= MODE_NORMAL;
      test_clock_select_pin_reg <= 1'b0;
      scan_reg <= 1'b0;
      test_mode_select_one_reg <= 1'b0;
      input_sign_nine_reg <= 1'b0;
      div_reg <= 7'h00;
    end else begin
      mode_reg <= mode_next;
      test_clock_select_pin_reg <= I_TEST_CLK_SEL;
      scan_reg <= I_SCAN_MODE;
      test_mode_select_one_reg <= I_TMS_ONE;
      input_sign_nine_reg <= I_SAT_SIGN[9];
      div_reg <= div_next;
    end
  end

  // registered pin drivers
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B) begin
      O_CH_SIGN <= '0;
      O_CH_MAG <= '0;
      O_TEST_SIGN <= 1'b0;
      O_TEST_MAG <= 1'b0;
      O_FE_TEST <= 1'b0;
      O_TIME_MARK <= 1'b0;
      O_SCAN_SHIFT <= 1'b0;
      O_SCAN_SERIAL <= 1'b0;
      O_CLK_PHASE <= '0;
      O_TDO <= 7'h00;
    end else begin
      O_CH_SIGN <= ch_sign_next;
      O_CH_MAG <= ch_mag_next;
      O_TEST_SIGN <= stg_if.sign;
      O_TEST_MAG <= stg_if.mag;
      O_FE_TEST <= bit_reg[BIT_FE_TEST];
      O_TIME_MARK <= mark_next;
      O_SCAN_SHIFT <= scan_reg;
      O_SCAN_SERIAL <= I_SCAN_SERIAL_IN;
      O_CLK_PHASE <= test_clock_select_pin_reg ? I_TCK : I_INT_PHASE;
      O_TDO <= tdo_next;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B) begin
      O_AUX_SIGN <= 7'h00;
      O_AUX_MAG <= 8'h00;
      O_TCK <= '0;
      O_AUX_SIGN_OE <= 7'h00;
      O_AUX_MAG_OE <= 8'h00;
      O_TCK_OE <= '0;
    end else begin
      O_AUX_SIGN <= obs_on ? obs_sign : 7'h00;
      O_AUX_MAG <= obs_on ? obs_mag : 8'h00;
      O_TCK <= obs_on ? obs_tck : 7'h00;
      O_AUX_SIGN_OE <= {7{obs_on}};
      O_AUX_MAG_OE <= {8{obs_on}};
      O_TCK_OE <= {7{obs_on}};
    end
  end
endmodule
